/* File: rtl/fail_out_pkg.sv */
`default_nettype none
package fail_out_pkg;
  // Core clock rate
  localparam longint unsigned CLK_HZ = 100_000_000;
  // Blink rate in millihertz, 1.25 Hz
  localparam longint unsigned BLINK_FREQ_MHZ = 1250;
  localparam int unsigned BLINK_CYCLES = int'(CLK_HZ * 1000 / BLINK_FREQ_MHZ);
  // Blink high share in percent
  localparam int unsigned BLINK_DUTY_PCT = 50;
  // Pulse-width frame rate in hertz
  localparam longint unsigned PWM_FREQ_HZ = 100;
  localparam int unsigned PWM_CYCLES = int'(CLK_HZ / PWM_FREQ_HZ);
  // Counter widths sized for the default frames
  localparam int BLINK_W = 27;
  localparam int PWM_W = 20;
  // Frame divisors for 20, 10, 5 and 2.5 percent
  localparam int unsigned DUTY_DIV_20 = 5;
  localparam int unsigned DUTY_DIV_10 = 10;
  localparam int unsigned DUTY_DIV_5 = 20;
  localparam int unsigned DUTY_DIV_2P5 = 40;
  // Duty encodings, the first is the reset default
  localparam logic [1:0] DUTY_SEL_20 = 2'h0;
  localparam logic [1:0] DUTY_SEL_10 = 2'h1;
  localparam logic [1:0] DUTY_SEL_5 = 2'h2;
  localparam logic [1:0] DUTY_SEL_2P5 = 2'h3;
  // Consecutive undervoltage events that trip the outputs
  localparam logic [2:0] UV_LIMIT = 3'h4;
  // Second watchdog failure count
  localparam logic [1:0] WD_SECOND = 2'h1;
  // Chip operating modes
  typedef enum logic [2:0] {
    MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE
  } sbc_mode_e;
  // Hardware configurations one to four
  typedef enum logic [1:0] {CFG_ONE, CFG_TWO, CFG_THREE, CFG_FOUR} hw_cfg_e;
  // Function of the blink and pulse pins
  typedef enum logic [2:0] {
    FUNC_FAIL, FUNC_OFF, FUNC_WAKE, FUNC_LOW_SIDE, FUNC_HIGH_SIDE
  } pin_func_e;
  // Three-state pad: level driven and drive enable
  typedef struct packed {
    logic out;
    logic oe;
  } pad_s;
  // Failure sources, all levels except the two event pulses
  typedef struct packed {
    logic watchdog_fault_flag;
    logic wd_trigger_ok;
    logic wd_disabled;
    logic thermal_shutdown_level_two;
    logic main_regulator_output_short;
    logic overvoltage;
    logic supply_overvoltage_reset_enable;
    logic undervoltage;
    logic undervoltage_ok;
  } fault_in_s;
  // Waveform counters
  typedef struct packed {
    logic [BLINK_W-1:0] blink_cnt;
    logic [PWM_W-1:0] pwm_cnt;
  } wave_state_s;
  // Fail logic state
  typedef struct packed {
    logic failure;
    logic wd_flag;
    logic [1:0] wd_cnt;
    logic [2:0] uv_cnt;
    logic cond_prev;
    logic fs_entry;
    pin_func_e [1:0] func_hold;
    logic [1:0] sw_hold;
    logic [1:0] lvl_prev;
    logic [1:0] wake_st;
    logic [1:0] lvl_st;
    pad_s pad_static;
    pad_s pad_blink;
    pad_s pad_pwm;
  } fail_state_s;
endpackage : fail_out_pkg
`default_nettype wire

/* File: rtl/fail_wave_gen.sv */
`timescale 1ns/1ps
`default_nettype none
// Blink and pulse-width waveforms, restarted at each activation
module fail_wave_gen #(
  parameter int unsigned BLINK_CYCLES = fail_out_pkg::BLINK_CYCLES,
  parameter int unsigned PWM_CYCLES = fail_out_pkg::PWM_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic run_in,
  input wire logic [1:0] duty_sel_in,
  output logic blink_on_out,
  output logic pwm_on_out
);
  localparam int BW = fail_out_pkg::BLINK_W;
  localparam int PW = fail_out_pkg::PWM_W;
  // Frame ends and blink half point
  localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_CYCLES - 1);
  localparam logic [BW-1:0] BLINK_HALF =
    BW'(BLINK_CYCLES * fail_out_pkg::BLINK_DUTY_PCT / 100);
  localparam logic [PW-1:0] PWM_LAST = PW'(PWM_CYCLES - 1);

  fail_out_pkg::wave_state_s st_q; // Counter state
  fail_out_pkg::wave_state_s st_d; // Next counter state
  logic [PW-1:0] pwm_thr; // Low time of one pulse frame

  // Duty threshold from the two-bit selection
  always_comb begin
    case (duty_sel_in)
      fail_out_pkg::DUTY_SEL_20: pwm_thr = PW'(PWM_CYCLES / fail_out_pkg::DUTY_DIV_20);
      fail_out_pkg::DUTY_SEL_10: pwm_thr = PW'(PWM_CYCLES / fail_out_pkg::DUTY_DIV_10);
      fail_out_pkg::DUTY_SEL_5: pwm_thr = PW'(PWM_CYCLES / fail_out_pkg::DUTY_DIV_5);
      default: pwm_thr = PW'(PWM_CYCLES / fail_out_pkg::DUTY_DIV_2P5);
    endcase
  end

  // Free counters while running, parked at zero otherwise (see R21)
  always_comb begin
    st_d = st_q;
    if (!run_in) begin
      st_d = '0;
    end else begin
      st_d.blink_cnt = (st_q.blink_cnt == BLINK_LAST) ? '0 : st_q.blink_cnt + 1'b1;
      st_d.pwm_cnt = (st_q.pwm_cnt == PWM_LAST) ? '0 : st_q.pwm_cnt + 1'b1;
    end
  end

  // Counter register
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Both waveforms start in their drive phase (see R13, see R14)
  assign blink_on_out = run_in && (st_q.blink_cnt < BLINK_HALF);
  assign pwm_on_out = run_in && (st_q.pwm_cnt < pwm_thr);
endmodule : fail_wave_gen
`default_nettype wire

/* File: rtl/fail_output_logic.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Watchdog failure activates, config one first, else second
// R2: Thermal level two or regulator short activates
// R3: Overvoltage activates only when reset-enable set
// R4: Four consecutive undervoltage events activate
// R5: Activation enters fail-safe, watchdog per configuration
// R6: Activation sets the fault-active flag
// R7: Test-force bit drives outputs, clearing releases them
// R8: Release only after causes gone and flag cleared
// R9: Controller retriggers watchdog before clearing the flag
// R10: Sleep, other fail-safe, stop disable clear watchdog flag
// R11: Configuration two ignores the first watchdog failure
// R12: All three pins drive low together, first static
// R13: Second pin blinks 1.25 Hz, half duty
// R14: Third pin pulses 100 Hz, selectable duty
// R15: Pins two, three default fail; remappable functions
// R16: Wake-configured pin records events in wake status
// R17: Switch pins drive, limiting is in the pad
// R18: Pin levels reported in normal and stop
// R19: Pin behaviour follows the chip mode
// R20: Leaving restart resumes functions, activation persists
// R21: Counter-made waveforms, pads released when inactive
module fail_output_logic #(
  parameter int unsigned BLINK_CYCLES = fail_out_pkg::BLINK_CYCLES,
  parameter int unsigned PWM_CYCLES = fail_out_pkg::PWM_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire fail_out_pkg::sbc_mode_e mode_in,
  input wire fail_out_pkg::hw_cfg_e config_sel_in,
  input wire fail_out_pkg::fault_in_s fault_in,
  input wire logic fail_out_test_force_in,
  input wire logic failure_clear_in,
  input wire logic [1:0] pwm_duty_select_in,
  input wire fail_out_pkg::pin_func_e [1:0] pin_func_in,
  input wire logic [1:0] switch_on_in,
  input wire logic [1:0] pin_level_in,
  input wire logic [1:0] wake_status_two_clear_in,
  output fail_out_pkg::pad_s fail_out_static_out,
  output fail_out_pkg::pad_s fail_out_blink_out,
  output fail_out_pkg::pad_s fail_out_pwm_out,
  output logic failure_flag_out,
  output logic watchdog_fault_flag_out,
  output logic fail_safe_entry_out,
  output logic [1:0] wake_status_two_out,
  output logic [1:0] pin_level_status_out
);
  fail_out_pkg::fail_state_s st_q; // Registered state
  fail_out_pkg::fail_state_s st_d; // Next state
  logic nonwd_cond; // Any non-watchdog cause present
  logic wd_act; // Watchdog failure that activates
  logic wd_to_fs; // That activation also enters fail-safe
  logic active; // Fail outputs are on
  logic blink_on; // Blink waveform in drive phase
  logic pwm_on; // Pulse waveform in drive phase
  logic [1:0] wave_on; // Per pin waveform, blink then pulse
  fail_out_pkg::pin_func_e [1:0] func_cfg; // Function as configured
  logic [1:0] sw_cfg; // Switch state as configured
  fail_out_pkg::pad_s [1:0] pad_d; // Next pad drive, blink then pulse

  // Waveform counters run only while activated
  fail_wave_gen #(
    .BLINK_CYCLES(BLINK_CYCLES),
    .PWM_CYCLES(PWM_CYCLES)
  ) u_wave (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .run_in(active),
    .duty_sel_in(pwm_duty_select_in),
    .blink_on_out(blink_on),
    .pwm_on_out(pwm_on)
  );

  // Cause decode
  always_comb begin
    // Thermal and short always count (see R2)
    nonwd_cond = fault_in.thermal_shutdown_level_two
               | fault_in.main_regulator_output_short;
    // Overvoltage only with its enable (see R3)
    nonwd_cond = nonwd_cond
               | (fault_in.overvoltage & fault_in.supply_overvoltage_reset_enable);
    // Four consecutive undervoltage events, the fourth counts at once (see R4)
    nonwd_cond = nonwd_cond | (st_q.uv_cnt == fail_out_pkg::UV_LIMIT);
    nonwd_cond = nonwd_cond
               | ((st_q.uv_cnt == (fail_out_pkg::UV_LIMIT - 3'h1)) & fault_in.undervoltage);
    // First failure in config one, second otherwise (see R1, see R11)
    wd_act = fault_in.watchdog_fault_flag
           & ((config_sel_in == fail_out_pkg::CFG_ONE) | (st_q.wd_cnt != 2'h0));
    // Configs one and three take watchdog activations to fail-safe (see R5)
    wd_to_fs = wd_act & ((config_sel_in == fail_out_pkg::CFG_ONE)
                       | (config_sel_in == fail_out_pkg::CFG_THREE));
    // Test force is independent of the fault flag (see R7)
    active = st_q.failure | fail_out_test_force_in;
  end

  // Configuration seen by the pins: live in normal, held elsewhere
  always_comb begin
    if (mode_in == fail_out_pkg::MODE_NORMAL) begin
      func_cfg = pin_func_in;
      sw_cfg = switch_on_in;
    end else begin
      // Held copy is never rewritten outside normal (see R20)
      func_cfg = st_q.func_hold;
      sw_cfg = st_q.sw_hold;
    end
    wave_on = {pwm_on, blink_on};
  end

  // Drive of the two remappable pins
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pad_d[i] = '0;
      case (func_cfg[i])
        // Fail function: open-drain low in drive phase (see R12, see R21)
        fail_out_pkg::FUNC_FAIL: begin
          pad_d[i].oe = active & wave_on[i];
        end
        // Low-side switch, off in restart and fail-safe (see R17, see R19)
        fail_out_pkg::FUNC_LOW_SIDE: begin
          pad_d[i].oe = sw_cfg[i] & (mode_in != fail_out_pkg::MODE_RESTART)
                      & (mode_in != fail_out_pkg::MODE_FAILSAFE);
        end
        // High-side switch, same gating, drives high (see R17, see R19)
        fail_out_pkg::FUNC_HIGH_SIDE: begin
          pad_d[i].out = 1'b1;
          pad_d[i].oe = sw_cfg[i] & (mode_in != fail_out_pkg::MODE_RESTART)
                      & (mode_in != fail_out_pkg::MODE_FAILSAFE);
        end
        // Wake input and off never drive
        default: begin
          pad_d[i] = '0;
        end
      endcase
    end
  end

  // Next state of the fail logic
  always_comb begin
    st_d = st_q;
    st_d.cond_prev = nonwd_cond;
    // Undervoltage counter, saturating, cleared by a good supply
    if (fault_in.undervoltage_ok) begin
      st_d.uv_cnt = 3'h0;
    end
    if (fault_in.undervoltage && st_q.uv_cnt != fail_out_pkg::UV_LIMIT) begin
      st_d.uv_cnt = st_q.uv_cnt + 3'h1; // see R4
    end
    // Fail-safe entry pulse on a fresh cause (see R5)
    st_d.fs_entry = (nonwd_cond & ~st_q.cond_prev) | wd_to_fs;
    // Watchdog flag clears, lower priority than a new failure (see R10)
    if (fault_in.wd_trigger_ok || mode_in == fail_out_pkg::MODE_SLEEP
        || (nonwd_cond && !st_q.cond_prev)
        || (mode_in == fail_out_pkg::MODE_STOP && fault_in.wd_disabled)) begin
      st_d.wd_flag = 1'b0;
      st_d.wd_cnt = 2'h0;
    end
    // Every watchdog failure sets the flag, the first one sets the count
    if (fault_in.watchdog_fault_flag) begin
      st_d.wd_flag = 1'b1;
      if (st_q.wd_cnt == 2'h0) begin
        st_d.wd_cnt = fail_out_pkg::WD_SECOND;
      end
    end
    // Fault clear: normal mode, causes gone, watchdog retriggered (see R8, see R9)
    if (failure_clear_in && mode_in == fail_out_pkg::MODE_NORMAL
        && !nonwd_cond && !st_q.wd_flag) begin
      st_d.failure = 1'b0;
      st_d.uv_cnt = 3'h0;
    end
    // Causes set the fault-active flag, set wins over clear (see R6)
    if (nonwd_cond || wd_act) begin
      st_d.failure = 1'b1;
    end
    // Configuration copy refreshed only in normal mode (see R19)
    if (mode_in == fail_out_pkg::MODE_NORMAL) begin
      st_d.func_hold = pin_func_in;
      st_d.sw_hold = switch_on_in;
    end
    st_d.lvl_prev = pin_level_in;
    for (int i = 0; i < 2; i++) begin
      // Software clear of a wake bit
      if (wake_status_two_clear_in[i]) begin
        st_d.wake_st[i] = 1'b0;
      end
      // Wake on either edge, off in fail-safe, set wins (see R16, see R19)
      if (func_cfg[i] == fail_out_pkg::FUNC_WAKE
          && mode_in != fail_out_pkg::MODE_FAILSAFE
          && pin_level_in[i] != st_q.lvl_prev[i]) begin
        st_d.wake_st[i] = 1'b1;
      end
      // Level report for general-purpose functions (see R18)
      if ((mode_in == fail_out_pkg::MODE_NORMAL || mode_in == fail_out_pkg::MODE_STOP)
          && func_cfg[i] != fail_out_pkg::FUNC_FAIL
          && func_cfg[i] != fail_out_pkg::FUNC_OFF) begin
        st_d.lvl_st[i] = pin_level_in[i];
      end
    end
    // First pin static low while active (see R12)
    st_d.pad_static.out = 1'b0;
    st_d.pad_static.oe = active;
    st_d.pad_blink = pad_d[0]; // see R13
    st_d.pad_pwm = pad_d[1]; // see R14, see R15
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      // Pins start in fail function, released (see R15)
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign fail_out_static_out = st_q.pad_static;
  assign fail_out_blink_out = st_q.pad_blink;
  assign fail_out_pwm_out = st_q.pad_pwm;
  assign failure_flag_out = st_q.failure;
  assign watchdog_fault_flag_out = st_q.wd_flag;
  assign fail_safe_entry_out = st_q.fs_entry;
  assign wake_status_two_out = st_q.wake_st;
  assign pin_level_status_out = st_q.lvl_st;

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // Steps of a fourth undervoltage event
  sequence uv_third_seen;
    st_q.uv_cnt == 3'h3;
  endsequence
  sequence uv_fourth_event;
    uv_third_seen and fault_in.undervoltage;
  endsequence

  // First watchdog failure outside config one, nothing else pending
  sequence wd_first_quiet;
    fault_in.watchdog_fault_flag && config_sel_in != fail_out_pkg::CFG_ONE
      && st_q.wd_cnt == 2'h0 && !st_q.failure && !nonwd_cond;
  endsequence

  wd_config_one_a: assert property ( // see R1
    fault_in.watchdog_fault_flag && config_sel_in == fail_out_pkg::CFG_ONE
      |=> st_q.failure ##1 fail_out_static_out.oe)
    else $error("config one watchdog failure did not activate");

  thermal_trip_a: assert property ( // see R2
    fault_in.thermal_shutdown_level_two |=> failure_flag_out)
    else $error("thermal shutdown did not set fault flag");

  ov_enabled_a: assert property ( // see R3
    fault_in.overvoltage && fault_in.supply_overvoltage_reset_enable
      |=> failure_flag_out)
    else $error("enabled overvoltage did not set fault flag");

  uv_fourth_a: assert property ( // see R4
    uv_fourth_event |=> failure_flag_out ##1 fail_out_static_out.oe)
    else $error("fourth undervoltage did not activate");

  fs_entry_a: assert property ( // see R5
    $rose(nonwd_cond) |=> fail_safe_entry_out)
    else $error("no fail-safe entry on new cause");

  flag_follows_a: assert property ( // see R6
    $rose(fail_out_static_out.oe) |-> $past(failure_flag_out || fail_out_test_force_in))
    else $error("activation without flag or test force");

  test_force_a: assert property ( // see R7
    fail_out_test_force_in |=> fail_out_static_out.oe)
    else $error("test force did not drive first pin");

  clear_blocked_a: assert property ( // see R8
    failure_flag_out && nonwd_cond |=> failure_flag_out)
    else $error("fault flag cleared while cause present");

  wd_sleep_clear_a: assert property ( // see R10
    mode_in == fail_out_pkg::MODE_SLEEP && !fault_in.watchdog_fault_flag |=> !watchdog_fault_flag_out)
    else $error("sleep did not clear watchdog flag");

  wd_first_skip_a: assert property ( // see R11
    wd_first_quiet |=> !failure_flag_out && watchdog_fault_flag_out)
    else $error("first watchdog failure activated outputs");

  pins_together_a: assert property ( // see R12
    $rose(fail_out_static_out.oe) && $past(func_cfg == '0)
      |-> fail_out_blink_out.oe && fail_out_pwm_out.oe && !fail_out_static_out.out)
    else $error("fail pins did not activate together");

  released_a: assert property ( // see R21
    !failure_flag_out && !fail_out_test_force_in |=> !fail_out_static_out.oe)
    else $error("first pin driven while inactive");

  // Steps of a watchdog activation that also enters fail-safe
  sequence wd_to_fs_seen;
    wd_to_fs;
  endsequence

  wd_fs_entry_a: assert property ( // see R5
    wd_to_fs_seen |=> fail_safe_entry_out)
    else $error("watchdog activation did not enter fail-safe");

  ov_blocked_a: assert property ( // see R3
    fault_in.overvoltage && !fault_in.supply_overvoltage_reset_enable && !nonwd_cond
      && !wd_act && !failure_flag_out |=> !failure_flag_out)
    else $error("disabled overvoltage set fault flag");

  wd_stop_clear_a: assert property ( // see R10
    mode_in == fail_out_pkg::MODE_STOP && fault_in.wd_disabled && !fault_in.watchdog_fault_flag
      |=> !watchdog_fault_flag_out)
    else $error("stop with watchdog off kept watchdog flag");

  force_release_a: assert property ( // see R7
    $fell(fail_out_test_force_in) && !st_q.failure && !nonwd_cond && !wd_act
      |=> !fail_out_static_out.oe)
    else $error("test force release left first pin driven");

  blink_start_a: assert property ( // see R13
    active && !$past(active) && func_cfg[0] == fail_out_pkg::FUNC_FAIL
      |=> fail_out_blink_out.oe)
    else $error("blink pin did not start in drive phase");

  wake_set_a: assert property ( // see R16
    func_cfg[1] == fail_out_pkg::FUNC_WAKE && mode_in != fail_out_pkg::MODE_FAILSAFE
      && pin_level_in[1] != st_q.lvl_prev[1] |=> wake_status_two_out[1])
    else $error("wake pin change not recorded");

  switch_restart_a: assert property ( // see R19
    mode_in == fail_out_pkg::MODE_RESTART && func_cfg[0] == fail_out_pkg::FUNC_LOW_SIDE
      |=> !fail_out_blink_out.oe)
    else $error("switch driven in restart");

  level_report_a: assert property ( // see R18
    mode_in == fail_out_pkg::MODE_NORMAL && func_cfg[1] == fail_out_pkg::FUNC_WAKE
      |=> pin_level_status_out[1] == $past(pin_level_in[1]))
    else $error("pin level not reported in normal mode");
endmodule : fail_output_logic
`default_nettype wire

/* File: verification/fail_lamp_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far side of the blink and pulse pins: lamps, pull-ups and outside sources
module fail_lamp_model (
  input wire fail_out_pkg::pad_s blink_pad_in,
  input wire fail_out_pkg::pad_s pwm_pad_in,
  input wire logic [1:0] ext_level_in,
  output logic [1:0] pin_level_out
);
  // A driving pad wins, a released pin shows the outside source or pull-up
  assign pin_level_out[0] = blink_pad_in.oe ? blink_pad_in.out : ext_level_in[0];
  assign pin_level_out[1] = pwm_pad_in.oe ? pwm_pad_in.out : ext_level_in[1];
endmodule : fail_lamp_model
`default_nettype wire

/* File: verification/tb_fail_output_logic.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the fail output block
module tb_fail_output_logic;
  // Short frames keep the waveform checks brief
  localparam int unsigned BLK = 40;
  localparam int unsigned PWM = 80;
  logic clk_in, rst_b_in, force_on, clr, flag, wdf, fse;
  fail_out_pkg::sbc_mode_e mode;
  fail_out_pkg::hw_cfg_e cfg;
  fail_out_pkg::fault_in_s flt;
  fail_out_pkg::pin_func_e [1:0] func;
  fail_out_pkg::pad_s p_st, p_bl, p_pw;
  logic [1:0] duty, sw_on, lvl, wk_clr, ext, wk_st, lvl_st;
  int error_cnt = 0;
  int total_checks = 0;
  int bl, pw, base;
  // Device under test
  fail_output_logic #(.BLINK_CYCLES(BLK), .PWM_CYCLES(PWM)) i_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .mode_in(mode), .config_sel_in(cfg),
    .fault_in(flt), .fail_out_test_force_in(force_on), .failure_clear_in(clr),
    .pwm_duty_select_in(duty), .pin_func_in(func), .switch_on_in(sw_on),
    .pin_level_in(lvl), .wake_status_two_clear_in(wk_clr),
    .fail_out_static_out(p_st), .fail_out_blink_out(p_bl), .fail_out_pwm_out(p_pw),
    .failure_flag_out(flag), .watchdog_fault_flag_out(wdf), .fail_safe_entry_out(fse),
    .wake_status_two_out(wk_st), .pin_level_status_out(lvl_st));
  // Far-side model
  fail_lamp_model i_lamp (.blink_pad_in(p_bl), .pwm_pad_in(p_pw), .ext_level_in(ext),
    .pin_level_out(lvl));
  // Clock at 100 MHz
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  // Wait n falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc
  // Expected drive-phase count of the pulse pin over one frame
  function automatic int unsigned pwm_hi(input logic [1:0] sel);
    case (sel)
      fail_out_pkg::DUTY_SEL_20: return PWM / fail_out_pkg::DUTY_DIV_20;
      fail_out_pkg::DUTY_SEL_10: return PWM / fail_out_pkg::DUTY_DIV_10;
      fail_out_pkg::DUTY_SEL_5: return PWM / fail_out_pkg::DUTY_DIV_5;
      default: return PWM / fail_out_pkg::DUTY_DIV_2P5;
    endcase
  endfunction : pwm_hi
  // Reset pulse of n cycles
  task automatic do_reset(input int n);
    rst_b_in = 1'b0;
    cyc(n);
    rst_b_in = 1'b1;
    cyc(1);
  endtask : do_reset
  // One watchdog failure pulse
  task automatic wd_pulse();
    flt.watchdog_fault_flag = 1'b1;
    cyc(1);
    flt.watchdog_fault_flag = 1'b0;
  endtask : wd_pulse
  // Software clear, then both flag and pads must be released
  task automatic release_chk();
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(2);
    chk({flag, p_st.oe, p_bl.oe, p_pw.oe}, 4'h0);
  endtask : release_chk
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  // Hang guard
  initial begin
    #500_000;
    error_cnt++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    rst_b_in = 1'b0;
    mode = fail_out_pkg::MODE_NORMAL;
    cfg = fail_out_pkg::CFG_ONE;
    flt = '0;
    force_on = 1'b0;
    clr = 1'b0;
    duty = fail_out_pkg::DUTY_SEL_20;
    func = {fail_out_pkg::FUNC_FAIL, fail_out_pkg::FUNC_FAIL};
    sw_on = 2'h0;
    wk_clr = 2'h0;
    ext = 2'h3;
    void'($urandom(92528));
    cyc(16);
    chk({flag, wdf, fse, p_st.oe, p_bl.oe, p_pw.oe, wk_st, lvl_st}, 0);
    rst_b_in = 1'b1;
    cyc(1);
    $display("test reset done");
    // Overvoltage without the enable must not trip
    flt.overvoltage = 1'b1;
    cyc(3);
    chk(flag, 1'b0);
    flt.overvoltage = 1'b0;
    flt.supply_overvoltage_reset_enable = 1'b1;
    // Each level cause trips flag, fail-safe entry and all three pads
    for (int i = 0; i < 3; i++) begin
      flt.thermal_shutdown_level_two = (i == 0);
      flt.main_regulator_output_short = (i == 1);
      flt.overvoltage = (i == 2);
      flt.supply_overvoltage_reset_enable = 1'b1;
      cyc(1);
      chk({flag, fse}, 2'h3);
      cyc(1);
      chk({p_st.oe, p_bl.oe, p_pw.oe, p_st.out, p_bl.out, p_pw.out}, 6'h38);
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(2);
      chk({flag, p_st.oe}, 2'h3);
      flt = '0;
      cyc(1);
      release_chk();
    end
    $display("test level causes done");
    // Undervoltage: count broken by a good event, then four in a row
    for (int n = 0; n < 8; n++) begin
      if (n == 3) begin
        flt.undervoltage_ok = 1'b1;
      end else begin
        flt.undervoltage = 1'b1;
      end
      cyc(1);
      flt = '0;
      chk(flag, n == 7);
      cyc(1);
    end
    // Good supply removes the undervoltage cause before the clear
    flt.undervoltage_ok = 1'b1;
    cyc(1);
    flt = '0;
    release_chk();
    $display("test undervoltage done");
    // Watchdog per configuration
    for (int c = 0; c < 4; c++) begin
      cfg = fail_out_pkg::hw_cfg_e'(c);
      do_reset(2);
      wd_pulse();
      chk({flag, wdf}, {c == 0, 1'b1});
      if (c != 0) begin
        cyc(1);
        wd_pulse();
        chk(flag, 1'b1);
      end
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(2);
      chk(flag, 1'b1);
      flt.wd_trigger_ok = 1'b1;
      cyc(1);
      flt.wd_trigger_ok = 1'b0;
      cyc(1);
      chk(wdf, 1'b0);
      release_chk();
    end
    // Sleep entry, then stop with the watchdog off, clear the watchdog flag
    for (int s = 0; s < 2; s++) begin
      cfg = fail_out_pkg::CFG_TWO;
      do_reset(2);
      wd_pulse();
      mode = s ? fail_out_pkg::MODE_STOP : fail_out_pkg::MODE_SLEEP;
      flt.wd_disabled = s[0];
      cyc(2);
      chk({wdf, flag}, 2'h0);
      mode = fail_out_pkg::MODE_NORMAL;
      flt.wd_disabled = 1'b0;
    end
    $display("test watchdog done");
    // Test force on and off
    force_on = 1'b1;
    cyc(1);
    chk({p_st.oe, p_bl.oe, p_pw.oe}, 3'h7);
    force_on = 1'b0;
    cyc(1);
    chk({flag, p_st.oe, p_bl.oe, p_pw.oe}, 4'h0);
    $display("test force done");
    // Waveforms for every duty code, from a random start code
    base = $urandom % 4;
    force_on = 1'b1;
    for (int k = 0; k < 4; k++) begin
      duty = 2'((base + k) % 4);
      cyc(2 * PWM);
      bl = 0;
      pw = 0;
      for (int t = 0; t < PWM; t++) begin
        bl += p_bl.oe;
        pw += p_pw.oe;
        cyc(1);
      end
      chk(32'(bl), PWM / 2);
      chk(32'(pw), pwm_hi(duty));
    end
    force_on = 1'b0;
    cyc(2);
    $display("test waveforms done");
    // Remapped pins: switch on pin zero, wake input on pin one
    func = {fail_out_pkg::FUNC_WAKE, fail_out_pkg::FUNC_LOW_SIDE};
    sw_on = 2'h1;
    cyc(4);
    chk({p_bl.oe, p_bl.out, lvl_st[0]}, 3'h4);
    func[0] = fail_out_pkg::FUNC_HIGH_SIDE;
    cyc(4);
    chk({p_bl.oe, p_bl.out, lvl_st[0]}, 3'h7);
    ext[1] = 1'b0;
    cyc(4);
    chk({wk_st, lvl_st[1]}, 3'h4);
    wk_clr = 2'h2;
    cyc(1);
    wk_clr = 2'h0;
    cyc(1);
    chk(wk_st, 2'h0);
    mode = fail_out_pkg::MODE_RESTART;
    cyc(1);
    ext[1] = $urandom % 2 ? 1'b1 : 1'b1;
    cyc(4);
    chk({p_bl.oe, wk_st[1]}, 2'h1);
    mode = fail_out_pkg::MODE_NORMAL;
    cyc(3);
    chk(p_bl.oe, 1'b1);
    wk_clr = 2'h2;
    mode = fail_out_pkg::MODE_FAILSAFE;
    cyc(1);
    wk_clr = 2'h0;
    ext[1] = 1'b0;
    cyc(4);
    chk({p_bl.oe, wk_st[1]}, 2'h0);
    $display("test pin functions done");
    report_and_stop();
  end
endmodule : tb_fail_output_logic
`default_nettype wire
